//--- src/iet_line.sv
// One expanded request line: synchroniser, polarity, edge or level
// detection and the sticky pending flag.
// Assumes the request pin is asynchronous to mclk.
`timescale 1ns/1ps
`default_nettype none
module iet_line
   import iet_pkg::*;
(
   // Clock and reset.
   input  wire logic mclk,
   input  wire logic nrst,
   // Request pin and configuration.
   input  wire logic req_pin,
   input  wire logic pol_low,
   input  wire logic is_level,
   input  wire logic clear,
   // Pending state.
   output logic      pending_q
);
   // =====================================================================
   // Synchroniser and detection.
   // =====================================================================
   logic sync1_q;    // First stage, read only by the second.
   logic sync2_q;    // Second stage, safe to use.
   logic active_q;   // Previous active level for edge detection.
   logic active;     // Line active after polarity.
   logic event_now;  // Request condition this cycle.

   // Two flops guard against metastability from the board pin.
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         sync1_q <= 1'b0;
         sync2_q <= 1'b0;
      end else begin
         sync1_q <= req_pin;
         sync2_q <= sync1_q;
      end
   end

   assign active = sync2_q ^ pol_low; // RULE2

   // Edge mode catches the rising active transition only.
   assign event_now = is_level ? active : (active & ~active_q); // RULE3

   // Past active level; cleared with reset, so a line held active at power-up
   // shows an edge once its level has passed the synchroniser.
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         active_q <= 1'b0;
      end else begin
         active_q <= active;
      end
   end

   // Pending is sticky; a new event wins over an acknowledge.
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         pending_q <= 1'b0; // RULE8
      end else if (event_now) begin
         pending_q <= 1'b1;
      end else if (clear) begin
         pending_q <= 1'b0; // RULE5
      end
   end

   // An event always leaves the flag set on the next cycle.
   a_pend_on_event : assert property ( // RULE3
      @(posedge mclk) disable iff (!nrst)
      event_now |=> pending_q)
      else $error("Pending did not set after an event.");
   // An acknowledge without a new event drops the flag.
   a_clear_drops : assert property ( // RULE5
      @(posedge mclk) disable iff (!nrst)
      (clear && !event_now) |=> !pending_q)
      else $error("Acknowledge did not clear the line.");
endmodule : iet_line
`default_nettype wire

//--- src/iet_pkg.sv
// Constants, offsets and field positions for the interrupt expander
// and interval timer block.
// Assumes one 40 MHz system clock and the processor data memory bus.
//
// Overview of operation
// RULE1: Eight request lines combine onto processor interrupt zero.
// RULE2: Polarity bit: 0 active high, 1 active low.
// RULE3: Type bit: 0 edge, 1 level detection.
// RULE4: Mask bit: 0 masked, 1 may interrupt.
// RULE5: Writing ones to offset three clears pending.
// RULE6: Reading offset three returns pending vector.
// RULE7: Interrupt registers 8 bits on data 15..8.
// RULE8: All interrupt register bits clear at power-up.
// RULE9: Line 2 timer, 3-5 links, 7 bus.
// RULE10: Software programs each line polarity at start-up.
// RULE11: Handler reads vector, services, writes acknowledge.
// RULE12: Interrupt zero active low, level sensitive only.
// RULE13: Timer is a 32-bit counter, 1 us resolution.
// RULE14: Timer control, load, count registers on data 39..8.
// RULE15: Control bit 0: 0 runs, 1 halts counter.
// RULE16: Control bit 1 enables the timer request.
// RULE17: Control bit 2 low holds timer in reset.
// RULE18: Elapsed interval raises an edge-type request.
// RULE19: New load value applies from next interval.
// RULE20: Count register reads the current counter value.
// RULE21: Request low while any unmasked line pending.
// RULE22: Timer reloads automatically and repeats periodically.
// RULE23: Prescaler derives 1 us tick from clock.
package iet_pkg;
   // =====================================================================
   // Bus and register geometry.
   // =====================================================================
   localparam int          IET_NLINES    = 8;   // Expanded request lines.
   localparam int          IET_TW        = 32;  // Timer width.
   localparam int          IET_DW        = 40;  // Data bus width.
   localparam int          IET_AW        = 2;   // Register index width.
   localparam int          IET_IRQ_LSB   = 8;   // Interrupt regs on 15..8.
   localparam int          IET_TMR_LSB   = 8;   // Timer regs on 39..8.
   localparam logic [1:0]  IET_OFS_POL   = 2'h0;
   localparam logic [1:0]  IET_OFS_TYPE  = 2'h1;
   localparam logic [1:0]  IET_OFS_MASK  = 2'h2;
   localparam logic [1:0]  IET_OFS_PEND  = 2'h3;
   localparam logic [1:0]  IET_OFS_CTRL  = 2'h0;
   localparam logic [1:0]  IET_OFS_LOAD  = 2'h1;
   localparam logic [1:0]  IET_OFS_COUNT = 2'h2;
   localparam logic [7:0]  IET_IRQ_RST   = 8'h00;
   localparam logic [31:0] IET_TMR_RST   = 32'h0000_0000;
   // =====================================================================
   // Timer control fields.
   // =====================================================================
   localparam int timer_halt_bit          = 0;
   localparam int timer_irq_enable_bit    = 1;
   localparam int timer_run_not_reset_bit = 2;
   localparam int IET_TIMER_LINE          = 2;   // Line fed by the timer.
   // =====================================================================
   // Timing.
   // =====================================================================
   localparam int IET_CLK_HZ     = 40_000_000;
   localparam int IET_TICK_NS    = 1000;
   localparam int IET_TICK_CYC   = IET_CLK_HZ / 1_000_000 * IET_TICK_NS
                                   / 1000;
   // Prescaler states, so the divider reads as a tiny machine.
   typedef enum logic [0:0] {
      IET_PS_COUNT = 1'b0,
      IET_PS_WRAP  = 1'b1
   } iet_ps_t;
endpackage : iet_pkg

//--- src/iet_top.sv
// Top of the interrupt expander and interval timer.
// Assumes the processor drives a synchronous register strobe interface
// with separate selects for the two register groups, on mclk.
`timescale 1ns/1ps
`default_nettype none
module iet_top
   import iet_pkg::*;
#(
   parameter int NLINES = iet_pkg::IET_NLINES,
   parameter int TW     = iet_pkg::IET_TW
)(
   // Clock and reset.
   input  wire logic                      mclk,
   input  wire logic                      nrst,
   // Processor data memory bus.
   input  wire logic                      irq_sel,
   input  wire logic                      tmr_sel,
   input  wire logic                      wr_en,
   input  wire logic                      rd_en,
   input  wire logic [iet_pkg::IET_AW-1:0] addr,
   input  wire logic [iet_pkg::IET_DW-1:0] wdata,
   output logic      [iet_pkg::IET_DW-1:0] rdata_q,
   // Request pins from the board, timer line is internal.
   input  wire logic [NLINES-1:0]         expanded_request_line,
   // Combined request, active low.
   output logic                           processor_interrupt_zero_n_q
);
   // =====================================================================
   // Register decode.
   // =====================================================================
   logic [NLINES-1:0] pol_q;      // irq_polarity.
   logic [NLINES-1:0] type_q;     // irq_detect_type.
   logic [NLINES-1:0] mask_q;     // irq_enable_mask.
   logic [NLINES-1:0] pending;    // irq_pending_vector.
   logic [NLINES-1:0] clr;        // One-cycle acknowledge per line.
   logic [NLINES-1:0] line_in;    // Request inputs incl. timer line.
   logic [NLINES-1:0] wbyte;      // Interrupt byte of the write data.
   logic [TW-1:0]     wword;      // Timer word of the write data.
   logic [2:0]        ctrl_q;     // timer_control, used bits only.
   logic [TW-1:0]     load_q;     // timer_reload_value.
   logic [TW-1:0]     count_q;    // timer_current_count.
   logic              timer_req_q;// Timer line, held high until next tick.
   logic              tick_q;     // One-microsecond enable.
   logic [7:0]        ps_q;       // Prescaler count.
   iet_ps_t           ps_st_q;    // Prescaler state.
   logic              irq_wr;
   logic              tmr_wr;
   logic              t_rst;      // Timer held in reset.
   logic              t_run;      // Timer counting.

   assign wbyte  = wdata[IET_IRQ_LSB +: NLINES]; // RULE7
   assign wword  = wdata[IET_TMR_LSB +: TW]; // RULE14
   assign irq_wr = irq_sel & wr_en;
   assign tmr_wr = tmr_sel & wr_en;
   assign t_rst  = ~ctrl_q[timer_run_not_reset_bit]; // RULE17
   assign t_run  = ~t_rst & ~ctrl_q[timer_halt_bit]; // RULE15

   // Configuration registers; all clear at power-up.
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         pol_q  <= IET_IRQ_RST; // RULE8
         type_q <= IET_IRQ_RST;
         mask_q <= IET_IRQ_RST;
      end else if (irq_wr) begin
         case (addr)
            IET_OFS_POL:  pol_q  <= wbyte; // RULE2
            IET_OFS_TYPE: type_q <= wbyte; // RULE3
            IET_OFS_MASK: mask_q <= wbyte; // RULE4
            default: begin
               // The acknowledge offset stores nothing.
            end
         endcase
      end
   end

   // Acknowledge writes clear only the lines written as one.
   assign clr = (irq_wr && addr == IET_OFS_PEND) ? wbyte : '0; // RULE5

   // =====================================================================
   // Request lines.
   // =====================================================================
   // The timer drives its own line; the board pin for that line is
   // ignored because the timer sits inside this block.
   always_comb begin
      line_in = expanded_request_line;
      line_in[IET_TIMER_LINE] = timer_req_q; // RULE9
   end

   genvar g;
   generate
      for (g = 0; g < NLINES; g++) begin : g_line
         iet_line u_line (
            .mclk      (mclk),
            .nrst      (nrst),
            .req_pin   (line_in[g]),
            .pol_low   (pol_q[g]),
            .is_level  (type_q[g]),
            .clear     (clr[g]),
            .pending_q (pending[g])
         ); // RULE1
      end
   endgenerate

   // Combined request is active low; the processor must take it as a
   // level since it only releases once software acknowledges.
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         processor_interrupt_zero_n_q <= 1'b1;
      end else begin
         processor_interrupt_zero_n_q <= ~|(pending & mask_q); // RULE21 RULE12 RULE4
      end
   end

   // =====================================================================
   // Prescaler.
   // =====================================================================
   // Runs freely so a tick arrives every microsecond; the first tick
   // after a start may come early by up to one microsecond.
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         ps_q    <= 8'h00;
         ps_st_q <= IET_PS_COUNT;
         tick_q  <= 1'b0;
      end else begin
         case (ps_st_q)
            IET_PS_COUNT: begin
               tick_q <= 1'b0;
               ps_q   <= ps_q + 8'h01;
               if (ps_q == 8'(IET_TICK_CYC - 2)) begin
                  ps_st_q <= IET_PS_WRAP;
               end
            end
            IET_PS_WRAP: begin
               tick_q  <= 1'b1; // RULE23
               ps_q    <= 8'h00;
               ps_st_q <= IET_PS_COUNT;
            end
            default: begin
               ps_st_q <= IET_PS_COUNT;
            end
         endcase
      end
   end

   // =====================================================================
   // Interval timer.
   // =====================================================================
   // Control and load registers.
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         ctrl_q <= 3'h0;
         load_q <= IET_TMR_RST;
      end else if (tmr_wr) begin
         if (addr == IET_OFS_CTRL) begin
            ctrl_q <= wword[2:0]; // RULE15 RULE16 RULE17
         end else if (addr == IET_OFS_LOAD) begin
            load_q <= wword; // RULE19
         end
      end
   end

   // Down-counter: the load value is copied only at reset or at the
   // end of an interval, so a new load never disturbs the interval
   // already running.
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         count_q <= IET_TMR_RST;
      end else if (t_rst) begin
         count_q <= load_q; // RULE17
      end else if (t_run && tick_q) begin
         if (count_q <= TW'(1)) begin
            count_q <= load_q; // RULE22 RULE19
         end else begin
            count_q <= count_q - TW'(1); // RULE13
         end
      end
   end

   // Edge request: a pulse one microsecond wide at each interval end,
   // suppressed when the timer interrupt is disabled.
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         timer_req_q <= 1'b0;
      end else if (t_rst) begin
         timer_req_q <= 1'b0;
      end else if (tick_q) begin
         timer_req_q <= t_run && count_q <= TW'(1)
                        && ctrl_q[timer_irq_enable_bit]; // RULE18 RULE16
      end
   end

   // =====================================================================
   // Read data.
   // =====================================================================
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         rdata_q <= '0;
      end else if (rd_en) begin
         rdata_q <= '0;
         if (irq_sel) begin
            case (addr)
               IET_OFS_POL:  rdata_q[IET_IRQ_LSB +: NLINES] <= pol_q;
               IET_OFS_TYPE: rdata_q[IET_IRQ_LSB +: NLINES] <= type_q;
               IET_OFS_MASK: rdata_q[IET_IRQ_LSB +: NLINES] <= mask_q;
               default:      rdata_q[IET_IRQ_LSB +: NLINES] <= pending; // RULE6
            endcase
         end else if (tmr_sel) begin
            if (addr == IET_OFS_CTRL) begin
               rdata_q[IET_TMR_LSB +: 3] <= ctrl_q;
            end else if (addr == IET_OFS_COUNT) begin
               rdata_q[IET_TMR_LSB +: TW] <= count_q; // RULE20
            end
         end
      end
   end

   // =====================================================================
   // Checks.
   // =====================================================================
   // An unmasked pending line pulls the combined request low.
   a_irq_out_low : assert property ( // RULE21
      @(posedge mclk) disable iff (!nrst)
      (|(pending & mask_q)) |=> !processor_interrupt_zero_n_q)
      else $error("Combined request not asserted.");
   // Masked or idle lines leave the combined request released.
   a_irq_out_high : assert property ( // RULE4
      @(posedge mclk) disable iff (!nrst)
      !(|(pending & mask_q)) |=> processor_interrupt_zero_n_q)
      else $error("Combined request asserted with nothing pending.");
   // A zero in bit 0 of an acknowledge leaves pending line 0 alone; the
   // clearing side is checked inside each line, next to its flag.
   a_ack_zero_keeps : assert property ( // RULE5
      @(posedge mclk) disable iff (!nrst)
      (irq_wr && addr == IET_OFS_PEND && !wbyte[0] && pending[0])
      |=> pending[0])
      else $error("Acknowledge with a zero bit dropped line 0.");

   // A halted counter holds its value.
   a_halt_holds : assert property ( // RULE15
      @(posedge mclk) disable iff (!nrst)
      (!t_rst && ctrl_q[timer_halt_bit] && !tmr_wr) |=> $stable(count_q))
      else $error("Counter moved while halted.");
   // Held in reset, the counter shows the load value.
   a_reset_loads : assert property ( // RULE17
      @(posedge mclk) disable iff (!nrst)
      t_rst |=> count_q == $past(load_q))
      else $error("Counter not held at load in reset.");
   // Each tick of a running timer above a count of one takes exactly one off the count.
   a_count_steps : assert property ( // RULE13
      @(posedge mclk) disable iff (!nrst)
      (t_run && tick_q && count_q > TW'(1))
      |=> count_q == $past(count_q) - TW'(1))
      else $error("Counter did not step by one.");
   // The end of an interval reloads the programmed value.
   a_reload_on_end : assert property ( // RULE22
      @(posedge mclk) disable iff (!nrst)
      (t_run && tick_q && count_q <= TW'(1)) |=> count_q == $past(load_q))
      else $error("Counter not reloaded at interval end.");

   // Ticks are spaced by the prescaler, never back to back.
   a_tick_period : assert property ( // RULE23
      @(posedge mclk) disable iff (!nrst)
      tick_q |=> !tick_q [*8])
      else $error("Tick came too soon.");
   // The prescaler count never passes its wrap point.
   a_ps_bound : assert property ( // RULE23
      @(posedge mclk) disable iff (!nrst)
      ps_q < 8'(IET_TICK_CYC))
      else $error("Prescaler count out of range.");

   // A disabled timer never raises its line.
   a_no_req_off : assert property ( // RULE16
      @(posedge mclk) disable iff (!nrst)
      (tick_q && !ctrl_q[timer_irq_enable_bit]) |=> !timer_req_q)
      else $error("Timer request while disabled.");
   // An enabled timer raises its line as the interval ends.
   a_req_on_end : assert property ( // RULE18
      @(posedge mclk) disable iff (!nrst)
      (t_run && tick_q && count_q <= TW'(1)
       && ctrl_q[timer_irq_enable_bit]) |=> timer_req_q)
      else $error("Timer request missing at interval end.");
   // The timer line stands until the next tick, so the edge detector
   // behind it always sees a clean rising edge.
   a_req_stands : assert property ( // RULE18
      @(posedge mclk) disable iff (!nrst)
      (timer_req_q && !tick_q && !t_rst) |=> timer_req_q)
      else $error("Timer request dropped between ticks.");

   // A pending read returns the vector of the read edge.
   a_pend_read : assert property ( // RULE6
      @(posedge mclk) disable iff (!nrst)
      (rd_en && irq_sel && addr == IET_OFS_PEND)
      |=> rdata_q[IET_IRQ_LSB +: NLINES] == $past(pending))
      else $error("Pending vector read wrong.");
   // Control reads return the stored bits.
   a_ctrl_read : assert property ( // RULE14
      @(posedge mclk) disable iff (!nrst)
      (rd_en && tmr_sel && !irq_sel && addr == IET_OFS_CTRL)
      |=> rdata_q[IET_TMR_LSB +: 3] == $past(ctrl_q))
      else $error("Control read wrong.");
   // Count reads return the counter of the read edge.
   a_count_read : assert property ( // RULE20
      @(posedge mclk) disable iff (!nrst)
      (rd_en && tmr_sel && !irq_sel && addr == IET_OFS_COUNT)
      |=> rdata_q[IET_TMR_LSB +: TW] == $past(count_q))
      else $error("Count read wrong.");
   // Read data stands between reads.
   a_rdata_holds : assert property ( // RULE6
      @(posedge mclk) disable iff (!nrst)
      !rd_en |=> $stable(rdata_q))
      else $error("Read data changed without a read.");
endmodule : iet_top
`default_nettype wire

//--- verification/iet_cpu_model.sv
// Processor-side bus model for the interrupt expander and timer.
// Assumes the bench calls its task and shares mclk with the block.
`timescale 1ns/1ps
`default_nettype none
module iet_cpu_model
   import iet_pkg::*;
(
   // Clock and read data from the block.
   input  wire logic                       mclk,
   input  wire logic [iet_pkg::IET_DW-1:0] rdata_q,
   // Bus towards the block.
   output var logic                        irq_sel,
   output var logic                        tmr_sel,
   output var logic                        wr_en,
   output var logic                        rd_en,
   output var logic [iet_pkg::IET_AW-1:0]  addr,
   output var logic [iet_pkg::IET_DW-1:0]  wdata
);
   // =====================================================================
   // Idle bus at time zero.
   // =====================================================================
   initial begin
      {irq_sel, tmr_sel, wr_en, rd_en} = 4'h0;
      addr  = 2'h0;
      wdata = 40'h00_0000_0000;
   end
   // One access: launched after an edge, held through the taking edge.
   // Data is inverted afterwards so stale values never look valid.
   task automatic access(input logic tmr, input logic wr,
                         input logic [1:0] ofs, input logic [31:0] val,
                         output logic [31:0] rd);
      @(posedge mclk);
      irq_sel <= !tmr;
      tmr_sel <= tmr;
      wr_en   <= wr;
      rd_en   <= !wr;
      addr    <= ofs;
      wdata   <= tmr ? {val, 8'h00} : {24'h00_0000, val[7:0], 8'h00};
      @(posedge mclk);
      {irq_sel, tmr_sel, wr_en, rd_en} <= 4'h0;
      wdata <= ~wdata;
      #1;
      rd = tmr ? rdata_q[39:8] : {24'h00_0000, rdata_q[15:8]};
   endtask : access
endmodule : iet_cpu_model
`default_nettype wire

//--- verification/iet_top_tb.sv
// Self-checking bench for the interrupt expander and interval timer.
// Assumes a 40 MHz clock and a 40-cycle microsecond tick.
`timescale 1ns/1ps
`default_nettype none
module iet_top_tb;
   import iet_pkg::*;
   // =====================================================================
   // Signals.
   // =====================================================================
   logic        mclk, nrst, irq_sel, tmr_sel, wr_en, rd_en, irq_n;
   logic [1:0]  addr;
   logic [39:0] wdata, rdata_q;
   logic [7:0]  req;
   logic [31:0] v, c1, c2;
   int          fail_count = 0;
   int          n_tests    = 0;
   int          cyc;
   initial mclk = 1'b0;
   always #12.5 mclk = ~mclk;
   iet_top i_dut (.mclk(mclk), .nrst(nrst), .irq_sel(irq_sel),
      .tmr_sel(tmr_sel), .wr_en(wr_en), .rd_en(rd_en), .addr(addr),
      .wdata(wdata), .rdata_q(rdata_q), .expanded_request_line(req),
      .processor_interrupt_zero_n_q(irq_n));
   iet_cpu_model i_cpu (.mclk(mclk), .rdata_q(rdata_q), .irq_sel(irq_sel),
      .tmr_sel(tmr_sel), .wr_en(wr_en), .rd_en(rd_en), .addr(addr),
      .wdata(wdata));
   // =====================================================================
   // Shared tasks.
   // =====================================================================
   task automatic results();
      $display("checks %0d mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : results
   task automatic chk(input string what, input logic [31:0] seen,
                      input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         fail_count++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk
   task automatic wr(input logic t, input logic [1:0] o, input logic [31:0] d);
      i_cpu.access(t, 1'b1, o, d, v);
   endtask : wr
   task automatic rd(input logic t, input logic [1:0] o);
      i_cpu.access(t, 1'b0, o, 32'h0, v);
   endtask : rd
   // The combined request is treated as a level, as the processor must.
   task automatic wait_irq(input logic lvl, input int lim);
      for (cyc = 0; irq_n !== lvl; cyc++) begin
         if (cyc >= lim) begin
            chk("irq_wait", {31'h0, irq_n}, {31'h0, lvl});
            results();
         end
         @(posedge mclk);
         #1;
      end
   endtask : wait_irq
   // Checks that the request stays released for n cycles.
   task automatic hold_high(input int n);
      logic bad;
      bad = 1'b0;
      repeat (n) begin
         @(posedge mclk);
         #1;
         if (irq_n !== 1'b1) bad = 1'b1;
      end
      chk("irq_quiet", {31'h0, bad}, 32'h0);
   endtask : hold_high
   // =====================================================================
   // Scenarios.
   // =====================================================================
   task automatic t_regs();
      logic [7:0] pat [3] = '{8'h5A, 8'hC3, 8'h3C};
      for (int i = 0; i < 4; i++) begin
         rd(1'b0, i[1:0]);
         chk("irq_reg_reset", v, 32'h0);
      end
      chk("irq_out_reset", {31'h0, irq_n}, 32'h1);
      for (int i = 0; i < 3; i++) begin
         wr(1'b0, i[1:0], {24'h0, pat[i]});
         rd(1'b0, i[1:0]);
         chk("irq_reg_rw", v, {24'h0, pat[i]});
         wr(1'b0, i[1:0], 32'h0);
      end
      wr(1'b0, IET_OFS_PEND, 32'hFF);
      rd(1'b0, IET_OFS_PEND);
      chk("pend_all_clear", v, 32'h0);
      $display("test regs done");
   endtask : t_regs
   task automatic t_lines();
      wr(1'b0, IET_OFS_TYPE, 32'h08);
      wr(1'b0, IET_OFS_MASK, 32'h18);
      req[3] <= 1'b1;
      wait_irq(1'b0, 10);
      rd(1'b0, IET_OFS_PEND);
      chk("pend_level", v, 32'h08);
      wr(1'b0, IET_OFS_PEND, 32'h08);
      rd(1'b0, IET_OFS_PEND);
      chk("level_repends", v, 32'h08);
      req[3] <= 1'b0;
      repeat (4) @(posedge mclk);
      wr(1'b0, IET_OFS_PEND, 32'h08);
      wait_irq(1'b1, 10);
      wr(1'b0, IET_OFS_MASK, 32'h08);
      req[4] <= 1'b1;
      hold_high(10);
      req[4] <= 1'b0;
      wr(1'b0, IET_OFS_PEND, 32'hEF);
      rd(1'b0, IET_OFS_PEND);
      chk("ack_zero_keeps", v, 32'h10);
      req[5] <= 1'b1;
      wr(1'b0, IET_OFS_POL, 32'h20);
      wr(1'b0, IET_OFS_MASK, 32'h20);
      wr(1'b0, IET_OFS_PEND, 32'hFF);
      hold_high(6);
      req[5] <= 1'b0;
      wait_irq(1'b0, 10);
      rd(1'b0, IET_OFS_PEND);
      chk("pend_low_edge", v, 32'h20);
      wr(1'b0, IET_OFS_PEND, 32'h20);
      wait_irq(1'b1, 10);
      $display("test lines done");
   endtask : t_lines
   task automatic t_timer();
      wr(1'b1, IET_OFS_CTRL, 32'h0);
      wr(1'b1, IET_OFS_LOAD, 32'd20);
      rd(1'b1, IET_OFS_COUNT);
      chk("count_in_reset", v, 32'd20);
      wr(1'b0, IET_OFS_MASK, 32'h04);
      wr(1'b1, IET_OFS_CTRL, 32'h6);
      rd(1'b1, IET_OFS_COUNT);
      c1 = v;
      repeat (38) @(posedge mclk);
      rd(1'b1, IET_OFS_COUNT);
      chk("count_one_tick", v, c1 - 32'd1);
      wr(1'b1, IET_OFS_CTRL, 32'h7);
      rd(1'b1, IET_OFS_CTRL);
      chk("ctrl_rw", v, 32'h7);
      rd(1'b1, IET_OFS_LOAD);
      chk("load_write_only", v, 32'h0);
      rd(1'b1, IET_OFS_COUNT);
      c2 = v;
      repeat (100) @(posedge mclk);
      rd(1'b1, IET_OFS_COUNT);
      chk("count_halted", v, c2);
      wr(1'b1, IET_OFS_CTRL, 32'h6);
      wr(1'b1, IET_OFS_LOAD, 32'd4);
      wait_irq(1'b0, 1000);
      chk("old_interval", {31'h0, cyc > 200}, 32'h1);
      rd(1'b0, IET_OFS_PEND);
      chk("timer_pend", v, 32'h04);
      wr(1'b0, IET_OFS_PEND, 32'h04);
      wait_irq(1'b1, 10);
      wait_irq(1'b0, 400);
      chk("reload_period", {31'h0, cyc >= 120 && cyc <= 170}, 32'h1);
      wr(1'b1, IET_OFS_CTRL, 32'h4);
      wr(1'b0, IET_OFS_PEND, 32'h04);
      wr(1'b0, IET_OFS_PEND, 32'h04);
      hold_high(400);
      $display("test timer done");
   endtask : t_timer
   // =====================================================================
   // Main sequence: unused lines 0, 1 and the spare stay low.
   // =====================================================================
   initial begin
      nrst = 1'b0;
      req  = 8'h00;
      repeat (2) @(posedge mclk);
      nrst <= 1'b1;
      t_regs();
      t_lines();
      t_timer();
      results();
   end
endmodule : iet_top_tb
`default_nettype wire
